// File: core/gamma_dac_regs.svh
`ifndef GAMMA_DAC_REGS_SVH
`define GAMMA_DAC_REGS_SVH

// Upper six bits of the 7-bit slave address; value is arbitrary
`define GD_SLAVE_ADDR_HIGH 6'h2B
// Pointer span and slot layout
`define GD_PTR_WIDTH 5
`define GD_LAST_SLOT 5'h1B
`define GD_FIRST_GAP_SLOT 5'h0C
`define GD_FIRST_BANK1_SLOT 5'h10
`define GD_BANK1_INDEX_OFFSET 5'h04
// Register array shape
`define GD_NUM_REGS 24
`define GD_IDX_WIDTH 5
`define GD_CODE_WIDTH 10
// Field positions inside the first data byte
`define GD_UPDATE_FLAG_BIT 7
`define GD_CODE_HIGH_MSB 1
// Reset value of every gamma code
`define GD_CODE_RESET 10'h000

`endif

// File: core/gamma_dac_pkg.sv
package gamma_dac_pkg;

	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_REG,
		ST_WDATA,
		ST_ACK,
		ST_RDATA,
		ST_MACK
	} i2c_state_t;

	// State of the serial engine
	typedef struct packed {
		i2c_state_t state;
		i2c_state_t after;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic byte_done;
		logic ack_ok;
		logic [4:0] ptr;
		logic hi_phase;
		logic [7:0] hold;
		logic sda_oe;
		logic sda_lvl;
		logic upd;
		logic wr_en;
		logic [4:0] wr_idx;
		logic [9:0] wr_data;
	} engine_t;

	// State of the line watcher
	typedef struct packed {
		logic scl_q;
		logic sda_q;
		logic scl_p;
		logic sda_p;
	} watch_t;

	// State of the code store
	typedef struct packed {
		logic [23:0][9:0] staged;
		logic [23:0][9:0] active;
	} store_t;

endpackage

// File: core/i2c_line_watch.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_line_watch (
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic scl, // Clock line level
	input wire logic sda, // Data line level
	output logic sda_now, // Registered data level
	output logic scl_rise, // Clock rising pulse
	output logic scl_fall, // Clock falling pulse
	output logic start_seen, // START or repeated START pulse
	output logic stop_seen // STOP pulse
);
	gamma_dac_pkg::watch_t r_reg;
	gamma_dac_pkg::watch_t r_next;

	////////////////////////////////////////////////////////////////////////////
	// Sample and keep one step of history
	always_comb begin
		r_next.scl_q = scl;
		r_next.sda_q = sda;
		r_next.scl_p = r_reg.scl_q;
		r_next.sda_p = r_reg.sda_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= 4'hF;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge and bus condition pulses
	assign sda_now = r_reg.sda_q;
	assign scl_rise = r_reg.scl_q & ~r_reg.scl_p;
	assign scl_fall = ~r_reg.scl_q & r_reg.scl_p;
	assign start_seen = r_reg.scl_q & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_q;
	assign stop_seen = r_reg.scl_q & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_q;
endmodule
`default_nettype wire

// File: core/gamma_code_store.sv
`timescale 1ns/1ns
`default_nettype none
`include "gamma_dac_regs.svh"
module gamma_code_store (
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic wr_en, // Write one code, pulse
	input wire logic [4:0] wr_idx, // Register index 0..23
	input wire logic [9:0] wr_data, // Code to write
	input wire logic upd, // Copy all codes to outputs, pulse
	input wire logic [4:0] rd_idx, // Read index
	output logic [9:0] rd_data, // Staged code at read index
	output logic [239:0] codes // Active codes, register 0 lowest
);
	gamma_dac_pkg::store_t r_reg;
	gamma_dac_pkg::store_t r_next;

	////////////////////////////////////////////////////////////////////////////
	// Staged write, then optional copy of the whole set
	always_comb begin
		r_next = r_reg;
		for (int i = 0; i < `GD_NUM_REGS; i++) begin
			if (wr_en && wr_idx == i[4:0]) begin
				r_next.staged[i] = wr_data;
			end
		end
		if (upd) begin
			r_next.active = r_next.staged; // Includes the word just written
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rd_data = (rd_idx < 5'h18) ? r_reg.staged[rd_idx] : `GD_CODE_RESET;
	assign codes = r_reg.active;
endmodule
`default_nettype wire

// File: core/gamma_dac_i2c.sv
// Contract
// R1 - Pointer auto-increments over 28 codes, reaching all 24 registers in a burst.
// R2 - Slots 12 through 15 (codes 0x0C-0x0F) are answered with NACK.
// R3 - From slot 16 onward acknowledge resumes, reaching the second bank.
// R4 - Master gives first address only; pointer advances after each two-byte word.
// R5 - Successive words go to consecutive registers until data stops or STOP.
// R6 - STOP or START before a second byte leaves that register unchanged.
// R7 - Master reads by writing register address, then repeated START with read bit.
// R8 - Device acknowledges write address, register address, then read address.
// R9 - Device sends contents from selected register on, auto-incrementing; master acknowledges.
// R10 - Master NACKs the last wanted byte, then sends STOP.
// R11 - Read ends and SDA is released on STOP, START or master NACK.
// R12 - Address byte bit 0 picks direction; zero means write.
// R13 - Code travels high byte first, bits 9:8 in first byte; write after second.
// R14 - Word with bit 15 set copies all codes to the outputs at once.
// R15 - Words aimed at unacknowledged slots are dropped, yet pointer still advances.
`timescale 1ns/1ns
`default_nettype none
`include "gamma_dac_regs.svh"
module gamma_dac_i2c (
	input wire logic CLK_SYS, // System clock, 250 MHz
	input wire logic RESET_N, // Async reset, active low
	input wire logic SCL, // Serial clock level
	input wire logic SDA_IN, // Serial data level
	output logic SDA_OUT, // Serial data drive level, always low
	output logic SDA_OE, // High while pulling data low
	input wire logic SLAVE_ADDRESS_SELECT_PIN, // Low bit of slave address
	output logic UPDATE_ALL, // One-cycle pulse when outputs are refreshed
	output logic [239:0] DAC_CODES // Active codes, register 0 in bits 9:0
);
	gamma_dac_pkg::engine_t r_reg;
	gamma_dac_pkg::engine_t r_next;

	logic sda_now;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [4:0] rd_idx;
	logic [9:0] rd_data;
	logic [7:0] rd_byte;

	////////////////////////////////////////////////////////////////////////////
	// Slot decoding

	// True for slots that hold a register
	function automatic logic slot_ok(input logic [4:0] slot);
		if (slot < `GD_FIRST_GAP_SLOT) begin
			slot_ok = 1'b1; // [R2]
		end else if (slot >= `GD_FIRST_BANK1_SLOT && slot <= `GD_LAST_SLOT) begin
			slot_ok = 1'b1; // [R3]
		end else begin
			slot_ok = 1'b0; // [R2]
		end
	endfunction

	// Register index of a slot, bank 1 folded down past the gap
	function automatic logic [4:0] slot_index(input logic [4:0] slot);
		if (slot >= `GD_FIRST_BANK1_SLOT) begin
			slot_index = slot - `GD_BANK1_INDEX_OFFSET;
		end else begin
			slot_index = slot;
		end
	endfunction

	// Pointer step with wrap after the last slot
	function automatic logic [4:0] next_ptr(input logic [4:0] slot);
		if (slot >= `GD_LAST_SLOT) begin
			next_ptr = 5'h00; // [R1]
		end else begin
			next_ptr = slot + 5'h01; // [R1]
		end
	endfunction

	// Address byte names this device; direction bit set aside
	function automatic logic addr_hit(input logic [7:0] b, input logic sel);
		addr_hit = (b[7:1] == {`GD_SLAVE_ADDR_HIGH, sel});
	endfunction

	// First byte of a code on the wire, flag and spare bits zero
	function automatic logic [7:0] code_high(input logic [9:0] code);
		code_high = {6'h00, code[9:8]}; // [R13]
	endfunction

	// Second byte of a code on the wire
	function automatic logic [7:0] code_low(input logic [9:0] code);
		code_low = code[7:0]; // [R13]
	endfunction

	// Code rebuilt from the held first byte and the second byte
	function automatic logic [9:0] code_join(input logic [7:0] hi, input logic [7:0] lo);
		code_join = {hi[`GD_CODE_HIGH_MSB:0], lo}; // [R13]
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus line watcher
	i2c_line_watch u_watch (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.scl(SCL),
		.sda(SDA_IN),
		.sda_now(sda_now),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	////////////////////////////////////////////////////////////////////////////
	// Code store
	gamma_code_store u_store (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.wr_en(r_reg.wr_en),
		.wr_idx(r_reg.wr_idx),
		.wr_data(r_reg.wr_data),
		.upd(r_reg.upd),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.codes(DAC_CODES)
	);

	////////////////////////////////////////////////////////////////////////////
	// Engine events
	logic bit_in; // Receive phase takes a data bit
	logic byte_in; // Received byte reaches its acknowledge slot
	logic next_byte; // Master acknowledged; load the next byte

	assign bit_in = scl_rise && !r_reg.byte_done;
	assign byte_in = scl_fall && r_reg.byte_done;
	assign next_byte = scl_fall && r_reg.ack_ok;

	////////////////////////////////////////////////////////////////////////////
	// Byte to send for the current pointer and half
	always_comb begin
		// Store index of the pointer's slot
		rd_idx = slot_index(r_reg.ptr);
		if (!slot_ok(r_reg.ptr)) begin
			rd_byte = 8'h00; // Gap slots read as zero
		end else if (!r_reg.hi_phase) begin
			rd_byte = code_high(rd_data); // [R13]
		end else begin
			rd_byte = code_low(rd_data); // [R13]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial engine
	always_comb begin
		// Hold by default; strobes last one cycle
		r_next = r_reg;
		r_next.wr_en = 1'b0;
		r_next.upd = 1'b0;
		r_next.sda_lvl = 1'b0;
		if (start_seen) begin
			// Fresh address phase; a half word in flight is dropped
			r_next.state = gamma_dac_pkg::ST_ADDR;
			r_next.bit_cnt = 3'h0;
			r_next.byte_done = 1'b0;
			r_next.ack_ok = 1'b0;
			r_next.hi_phase = 1'b0; // [R6]
			r_next.sda_oe = 1'b0; // [R11]
		end else if (stop_seen) begin
			// Bus released; session over
			r_next.state = gamma_dac_pkg::ST_IDLE;
			r_next.byte_done = 1'b0;
			r_next.ack_ok = 1'b0;
			r_next.hi_phase = 1'b0; // [R6]
			r_next.sda_oe = 1'b0; // [R11]
		end else begin
			case (r_reg.state)
				gamma_dac_pkg::ST_ADDR, gamma_dac_pkg::ST_REG, gamma_dac_pkg::ST_WDATA: begin
					// Receive phases share the shifter
					if (bit_in) begin
						// Shift in, MSB first
						r_next.shift = {r_reg.shift[6:0], sda_now};
						r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
						if (r_reg.bit_cnt == 3'h7) begin
							r_next.byte_done = 1'b1;
						end
					end else if (byte_in) begin
						// Byte complete; acknowledge slot follows
						r_next.byte_done = 1'b0;
						r_next.state = gamma_dac_pkg::ST_ACK;
						case (r_reg.state)
							gamma_dac_pkg::ST_ADDR: begin
								// Own address acknowledged; others ignored
								if (addr_hit(r_reg.shift, SLAVE_ADDRESS_SELECT_PIN)) begin
									r_next.sda_oe = 1'b1; // [R8]
									r_next.hi_phase = 1'b0;
									if (r_reg.shift[0]) begin
										r_next.after = gamma_dac_pkg::ST_RDATA; // [R12]
									end else begin
										r_next.after = gamma_dac_pkg::ST_REG; // [R12]
									end
								end else begin
									r_next.state = gamma_dac_pkg::ST_IDLE;
								end
							end
							gamma_dac_pkg::ST_REG: begin
								// Register byte loads the pointer
								r_next.ptr = r_reg.shift[4:0];
								r_next.hi_phase = 1'b0;
								r_next.sda_oe = slot_ok(r_reg.shift[4:0]); // [R2] [R3] [R8]
								r_next.after = gamma_dac_pkg::ST_WDATA;
							end
							default: begin
								// Data byte, first half then second half
								r_next.sda_oe = slot_ok(r_reg.ptr); // [R2] [R3]
								r_next.after = gamma_dac_pkg::ST_WDATA; // [R5]
								if (!r_reg.hi_phase) begin
									r_next.hold = r_reg.shift; // [R13]
									r_next.hi_phase = 1'b1;
								end else begin
									// Second byte completes the word
									if (slot_ok(r_reg.ptr)) begin
										r_next.wr_en = 1'b1; // [R13] [R15]
										r_next.wr_idx = slot_index(r_reg.ptr);
										r_next.wr_data = code_join(r_reg.hold, r_reg.shift); // [R13]
										r_next.upd = r_reg.hold[`GD_UPDATE_FLAG_BIT]; // [R14]
									end
									r_next.ptr = next_ptr(r_reg.ptr); // [R4] [R15]
									r_next.hi_phase = 1'b0;
								end
							end
						endcase
					end
				end
				gamma_dac_pkg::ST_ACK: begin
					// Acknowledge slot ends on the clock fall
					if (scl_fall) begin
						r_next.state = r_reg.after;
						r_next.bit_cnt = 3'h0;
						r_next.sda_oe = 1'b0;
						if (r_reg.after == gamma_dac_pkg::ST_RDATA) begin
							// First bit of the first read byte
							r_next.shift = rd_byte; // [R9]
							r_next.sda_oe = ~rd_byte[7];
						end
					end
				end
				gamma_dac_pkg::ST_RDATA: begin
					// Shift out, most significant bit first
					if (scl_fall) begin
						if (r_reg.bit_cnt == 3'h7) begin
							// Eighth bit out; release for the answer
							r_next.sda_oe = 1'b0;
							r_next.state = gamma_dac_pkg::ST_MACK;
						end else begin
							r_next.shift = {r_reg.shift[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.shift[6];
							r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
						end
					end
				end
				gamma_dac_pkg::ST_MACK: begin
					// Master answer to the byte just sent
					if (scl_rise) begin
						if (sda_now) begin
							r_next.state = gamma_dac_pkg::ST_IDLE; // [R11]
						end else begin
							r_next.ack_ok = 1'b1; // [R9]
							r_next.hi_phase = ~r_reg.hi_phase;
							if (r_reg.hi_phase) begin
								r_next.ptr = next_ptr(r_reg.ptr); // [R1] [R9]
							end
						end
					end else if (next_byte) begin
						// Load the next byte of the burst
						r_next.ack_ok = 1'b0;
						r_next.state = gamma_dac_pkg::ST_RDATA;
						r_next.bit_cnt = 3'h0;
						r_next.shift = rd_byte; // [R9]
						r_next.sda_oe = ~rd_byte[7];
					end
				end
				gamma_dac_pkg::ST_IDLE: begin
					// Nothing to do until a START
					r_next.sda_oe = 1'b0;
				end
				default: begin
					// Unused codes fall back to idle
					r_next.state = gamma_dac_pkg::ST_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// Engine state register
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin outputs
	assign SDA_OUT = r_reg.sda_lvl;
	assign SDA_OE = r_reg.sda_oe;
	assign UPDATE_ALL = r_reg.upd;
endmodule
`default_nettype wire

// File: verif/gamma_dac_i2c_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module gamma_dac_i2c_asserts (
	input wire logic CLK_SYS, // System clock
	input wire logic RESET_N, // Async reset, active low
	input wire logic SCL, // Clock line
	input wire logic SDA_IN, // Data wire
	input wire logic SDA_OUT, // Drive level
	input wire logic SDA_OE, // Drive enable
	input wire logic SLAVE_ADDRESS_SELECT_PIN, // Address pin
	input wire logic UPDATE_ALL, // Update pulse
	input wire logic [239:0] DAC_CODES // Active codes
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	////////////////////////////////////////////////////////////////
	// Line drive
	a_drive_only_low: assert property (SDA_OUT == 1'b0)
		else $error("data drive level not low");
	a_oe_stable_high: assert property ($rose(SCL) |=> $stable(SDA_OE) [*3])
		else $error("drive moved while clock high");
	a_oe_moves_low: assert property ($changed(SDA_OE) |-> !SCL && !$past(SCL))
		else $error("drive moved outside clock low");
	a_oe_min_hold: assert property ($rose(SDA_OE) |=> SDA_OE [*4])
		else $error("drive pulse too short");
	////////////////////////////////////////////////////////////////
	// Output refresh
	a_update_single: assert property (UPDATE_ALL |=> !UPDATE_ALL)
		else $error("update pulse too long");
	a_codes_need_update: assert property ($changed(DAC_CODES) |-> $past(UPDATE_ALL))
		else $error("codes moved without update");
	a_update_in_ack: assert property (UPDATE_ALL |-> SDA_OE && !SCL)
		else $error("update outside acknowledge");
	a_quiet_in_reset: assert property (disable iff (1'b0)
		!RESET_N |-> !SDA_OE && !UPDATE_ALL && DAC_CODES == '0)
		else $error("outputs active in reset");
	// Main scenarios
	c_update: cover property (UPDATE_ALL);
	c_drive: cover property ($rose(SDA_OE));
	c_release: cover property ($fell(SDA_OE));
endmodule
bind gamma_dac_i2c gamma_dac_i2c_asserts gamma_dac_i2c_asserts_inst (.CLK_SYS(CLK_SYS),
	.RESET_N(RESET_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.SLAVE_ADDRESS_SELECT_PIN(SLAVE_ADDRESS_SELECT_PIN), .UPDATE_ALL(UPDATE_ALL),
	.DAC_CODES(DAC_CODES));
`default_nettype wire

// File: verif/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
	input wire logic clk, // System clock
	output logic scl, // Clock line level
	output logic sda_low, // High while pulling data low
	input wire logic sda // Resolved data wire
);
	// Bus idle at start
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Half period of the serial clock
	task automatic hp();
		repeat (8) @(negedge clk);
	endtask
	// One bit out, wire level seen at end of clock high
	task automatic xbit(input logic b, output logic r);
		repeat (2) @(negedge clk);
		sda_low = !b;
		hp();
		scl = 1'b1;
		hp();
		r = sda;
		scl = 1'b0;
	endtask
	// START or repeated START
	task automatic start();
		repeat (2) @(negedge clk);
		sda_low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	// STOP, bus left idle
	task automatic stop();
		repeat (2) @(negedge clk);
		sda_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b0;
		hp();
	endtask
	// Byte out, most significant first; ack back
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(b[i], r);
		xbit(1'b1, r);
		ack = !r;
	endtask
	// Byte in, then ACK or NACK on the last one
	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, b[i]);
		xbit(nack, r);
	endtask
endmodule
`default_nettype wire

// File: verif/gamma_dac_i2c_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "gamma_dac_regs.svh"
`define M i2c_master_model_inst
`define CHK(g, e) begin \
	compares++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module gamma_dac_i2c_tb_top;
	logic clk, rst_n, pin, scl, m_low, oe, upd;
	wire logic sda;
	logic [239:0] codes;
	logic [9:0] staged [24];
	logic [9:0] active [24];
	int fails, compares, seed, pulses, expp;
	// Open-drain wire with pull-up
	assign sda = !(oe || m_low);
	gamma_dac_i2c gamma_dac_i2c_inst (.CLK_SYS(clk), .RESET_N(rst_n), .SCL(scl),
		.SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe), .SLAVE_ADDRESS_SELECT_PIN(pin),
		.UPDATE_ALL(upd), .DAC_CODES(codes));
	i2c_master_model i2c_master_model_inst (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));
	////////////////////////////////////////////////////////////////
	// Clock and update pulse count
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (upd === 1'b1)
			pulses <= pulses + 1;
	end
	// Store index of a slot, -1 in the gap
	function automatic int idx(input logic [4:0] s);
		if (s < `GD_FIRST_GAP_SLOT)
			return s;
		if (s >= `GD_FIRST_BANK1_SLOT && s <= `GD_LAST_SLOT)
			return s - `GD_BANK1_INDEX_OFFSET;
		return -1;
	endfunction
	function automatic logic [4:0] nxt(input logic [4:0] s);
		return s == `GD_LAST_SLOT ? 5'h00 : s + 5'h01;
	endfunction
	function automatic logic [239:0] pack();
		for (int i = 0; i < 24; i++)
			pack[10 * i +: 10] = active[i];
	endfunction
	// Random slot that is acknowledged
	function automatic logic [4:0] rs();
		logic [4:0] s;
		s = 5'({$random(seed)} % 24);
		return s < 5'h0C ? s : s + 5'h04;
	endfunction
	////////////////////////////////////////////////////////////////
	// START and address byte
	task automatic sess(input logic [6:0] a, input logic r, input logic e);
		logic k;
		`M.start();
		`M.wbyte({a, r}, k);
		`CHK(k, e)
	endtask
	// Burst write, optional lone high byte before STOP
	task automatic wr(input logic [4:0] s, input int n, input logic fl, input logic cut);
		logic a;
		logic [9:0] c;
		logic [7:0] h;
		sess({`GD_SLAVE_ADDR_HIGH, pin}, 1'b0, 1'b1);
		`M.wbyte({3'h0, s}, a);
		`CHK(a, 1'b1)
		for (int k = 0; k < n; k++) begin
			c = 10'($random(seed));
			h = 8'($random(seed));
			h[7] = fl && k == n - 1 && idx(s) >= 0;
			h[1:0] = c[9:8];
			`M.wbyte(h, a);
			`CHK(a, idx(s) >= 0)
			`M.wbyte(c[7:0], a);
			`CHK(a, idx(s) >= 0)
			if (idx(s) >= 0)
				staged[idx(s)] = c;
			if (h[7]) begin
				active = staged;
				expp++;
			end
			s = nxt(s);
		end
		if (cut)
			`M.wbyte(8'h83, a);
		`M.stop();
		`CHK(codes, pack())
		`CHK(pulses, expp)
	endtask
	// Read burst, master NACKs the last byte
	task automatic rd(input logic [4:0] s, input int n);
		logic a;
		logic [7:0] b;
		sess({`GD_SLAVE_ADDR_HIGH, pin}, 1'b0, 1'b1);
		`M.wbyte({3'h0, s}, a);
		`CHK(a, 1'b1)
		sess({`GD_SLAVE_ADDR_HIGH, pin}, 1'b1, 1'b1);
		for (int k = 0; k < n; k++) begin
			`M.rbyte(1'b0, b);
			`CHK(b, idx(s) >= 0 ? {6'h00, staged[idx(s)][9:8]} : 8'h00)
			`M.rbyte(k == n - 1, b);
			`CHK(b, idx(s) >= 0 ? staged[idx(s)][7:0] : 8'h00)
			s = nxt(s);
		end
		repeat (8) @(negedge clk);
		`CHK(oe, 1'b0)
		`M.stop();
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 28438;
		rst_n = 1'b0;
		pin = 1'b0;
		fails = 0;
		compares = 0;
		pulses = 0;
		expp = 0;
		foreach (staged[i]) begin
			staged[i] = 10'h000;
			active[i] = 10'h000;
		end
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(codes, 240'h0)
		wr(5'h00, 28, 1'b1, 1'b0);
		rd(5'h00, 28);
		wr(5'h1A, 4, 1'b1, 1'b1);
		for (int t = 0; t < 10; t++) begin
			pin = 1'($random(seed));
			sess({~`GD_SLAVE_ADDR_HIGH, pin}, 1'b0, 1'b0);
			sess({`GD_SLAVE_ADDR_HIGH, !pin}, 1'b1, 1'b0);
			`M.stop();
			wr(rs(), 1 + {$random(seed)} % 6, 1'($random(seed)), 1'($random(seed)));
			rd(rs(), 1 + {$random(seed)} % 6);
		end
		tally_and_finish();
	end
	// Hang guard
	initial begin
		repeat (95000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
